// ---- smp_pkg.sv ----
// Shared constants and carrier types for the serial MRAM command block
package smp_pkg;

	// Array geometry: 512K bytes, 19 decoded address bits
	localparam int ADDR_W = 19;
	localparam int DATA_W = 8;

	// Command opcodes
	localparam logic [7:0] OP_SET_WRITE_LATCH   = 8'h06;
	localparam logic [7:0] OP_CLEAR_WRITE_LATCH = 8'h04;
	localparam logic [7:0] OP_STATUS_READ       = 8'h05;
	localparam logic [7:0] OP_STATUS_WRITE      = 8'h01;
	localparam logic [7:0] OP_READ              = 8'h03;
	localparam logic [7:0] OP_WRITE             = 8'h02;
	localparam logic [7:0] OP_SLEEP             = 8'hB9;
	localparam logic [7:0] OP_WAKE              = 8'hAB;
	localparam logic [7:0] OP_NONE              = 8'h00;

	// Status register field positions
	localparam int ST_LOCK_BIT   = 7;
	localparam int ST_SPARE6_BIT = 6;
	localparam int ST_SPARE4_BIT = 4;
	localparam int ST_BP_HI_BIT  = 3;
	localparam int ST_BP_LO_BIT  = 2;
	localparam int ST_LATCH_BIT  = 1;
	localparam int ST_SPARE0_BIT = 0;
	localparam logic [7:0] STATUS_RST = 8'h00;

	// Frame framing
	localparam logic [2:0] BIT_LAST       = 3'h7;
	localparam logic [1:0] ADDR_BYTE_LAST = 2'h2;

	// Block-protect encodings and the address bits that mark protected areas
	localparam logic [1:0] BP_NONE    = 2'h0;
	localparam logic [1:0] BP_QUARTER = 2'h1;
	localparam logic [1:0] BP_HALF    = 2'h2;
	localparam logic [1:0] BP_ALL     = 2'h3;
	localparam logic [1:0] TOP_QUARTER = 2'h3;

	typedef enum logic [1:0]
	{
		PH_OP,
		PH_ADDR,
		PH_DATA,
		PH_DONE
	} smp_phase_t;

	typedef struct packed
	{
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} smp_wr_t;

	typedef struct packed
	{
		logic [7:0] status;
		logic       sleeping;
	} smp_stat_t;

endpackage

// ---- smp_mram_cmd.sv ----
// Serial MRAM command decoder, status register and write protection
`timescale 1ns/100ps

module smp_mram_cmd
(
	input  wire logic                       clk_i,
	input  wire logic                       sys_rst_i,
	input  wire logic                       sck_i,
	input  wire logic                       cs_n_i,
	input  wire logic                       si_i,
	input  wire logic                       wp_n_i,
	output logic                            so_o,
	output logic                            so_oe_n_o,
	output logic [smp_pkg::ADDR_W-1:0]      mem_raddr_o,
	input  wire logic [smp_pkg::DATA_W-1:0] mem_rdata_i,
	output logic                            mem_wr_o,
	output smp_pkg::smp_wr_t                mem_wreq_o,
	output smp_pkg::smp_stat_t              status_o
);
	import smp_pkg::*;

	// Link-side frame state, cleared whenever chip select is high, except addr_q
	logic              frame_rst;
	smp_phase_t        phase_q;
	logic [2:0]        bit_q;
	logic [6:0]        sh_q;
	logic [7:0]        op_q;
	logic [1:0]        addr_cnt_q;
	logic [ADDR_W-1:0] addr_q;

	// Persistent state, kept across frames; power-up reset loads it
	logic              latch_q;
	logic              lock_q;
	logic [1:0]        bp_q;
	logic [3:0]        spare_q;
	logic              sleeping_q;
	logic              wp_meta_q;
	logic              wp_sync_q;

	// Output shifter on the falling edge
	logic [7:0]        tx_q;
	logic              so_q;
	logic              oe_n_q;

	// Crossing into the system clock
	smp_wr_t           wr_hold_q;
	logic              wr_tgl_q;
	logic              st_tgl_q;
	logic [2:0]        wr_sync_q;
	logic [2:0]        st_sync_q;

	logic [7:0]        rx_byte;
	logic              byte_done;
	logic              cmd_ok;
	logic              op_evt;
	logic              st_wr_evt;
	logic              st_wr_ok;
	logic              blk_prot;
	logic              arr_wr_evt;
	logic              load_rd;
	logic              load_st;
	logic [7:0]        status;
	smp_stat_t         stat_live;

	// Chip select high aborts the frame at once; no clock edge follows it
	assign frame_rst = sys_rst_i | cs_n_i;

	assign rx_byte   = {sh_q, si_i};
	assign byte_done = (bit_q == BIT_LAST);

	// While asleep every opcode but wake is ignored
	assign cmd_ok = !sleeping_q || (rx_byte == OP_WAKE);

	assign op_evt = (phase_q == PH_OP) && byte_done && cmd_ok;

	// Status write allowed only with latch set and lock or pin permitting
	assign st_wr_ok = latch_q && (!lock_q || wp_sync_q);

	assign st_wr_evt = (phase_q == PH_DATA) && byte_done
		&& (op_q == OP_STATUS_WRITE) && st_wr_ok;

	// Protected range from the two protect bits
	always_comb
	begin
		unique case (bp_q)
			BP_NONE:
			begin
				blk_prot = 1'b0;
			end
			BP_QUARTER:
			begin
				blk_prot = (addr_q[ADDR_W-1:ADDR_W-2] == TOP_QUARTER);
			end
			BP_HALF:
			begin
				blk_prot = addr_q[ADDR_W-1];
			end
			BP_ALL:
			begin
				blk_prot = 1'b1;
			end
		endcase
	end

	assign arr_wr_evt = (phase_q == PH_DATA) && byte_done
		&& (op_q == OP_WRITE) && latch_q && !blk_prot;

	// Field layout of the status byte
	always_comb
	begin
		status                              = STATUS_RST;
		status[ST_LOCK_BIT]                 = lock_q;
		status[ST_SPARE6_BIT:ST_SPARE4_BIT] = spare_q[3:1];
		status[ST_BP_HI_BIT:ST_BP_LO_BIT]   = bp_q;
		status[ST_LATCH_BIT]                = latch_q;
		status[ST_SPARE0_BIT]               = spare_q[0];
	end

	assign stat_live = '{status: status, sleeping: sleeping_q};

	// Bit counter and input shifter, sampled on the rising edge
	always_ff @(posedge sck_i or posedge frame_rst)
	begin
		if (frame_rst)
		begin
			bit_q <= 3'h0;
			sh_q  <= 7'h00;
		end
		else
		begin
			bit_q <= bit_q + 3'h1;
			sh_q  <= rx_byte[6:0];
		end
	end

	// Frame phase: opcode, address bytes, data bytes, then ignore the rest
	always_ff @(posedge sck_i or posedge frame_rst)
	begin
		if (frame_rst)
		begin
			phase_q    <= PH_OP;
			op_q       <= OP_NONE;
			addr_cnt_q <= 2'h0;
		end
		else if (byte_done)
		begin
			unique case (phase_q)
				PH_OP:
				begin
					op_q <= cmd_ok ? rx_byte : OP_NONE;
					if (!cmd_ok)
						phase_q <= PH_DONE;
					else if (rx_byte == OP_READ || rx_byte == OP_WRITE)
						phase_q <= PH_ADDR;
					else if (rx_byte == OP_STATUS_READ
						|| rx_byte == OP_STATUS_WRITE)
						phase_q <= PH_DATA;
					else
						phase_q <= PH_DONE;
				end
				PH_ADDR:
				begin
					addr_cnt_q <= addr_cnt_q + 2'h1;
					if (addr_cnt_q == ADDR_BYTE_LAST)
						phase_q <= PH_DATA;
				end
				PH_DATA:
				begin
					// Only one status byte per frame is written
					if (op_q == OP_STATUS_WRITE)
						phase_q <= PH_DONE;
				end
				PH_DONE:
				begin
					phase_q <= PH_DONE;
				end
			endcase
		end
	end

	// Address counter; kept across frames, reloaded by every address phase
	always_ff @(posedge sck_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			addr_q <= '0;
		else if (!cs_n_i && byte_done && phase_q == PH_ADDR)
			addr_q <= {addr_q[ADDR_W-9:0], rx_byte};
		else if (!cs_n_i && byte_done && phase_q == PH_DATA
			&& (op_q == OP_READ || op_q == OP_WRITE))
			addr_q <= addr_q + 1'b1;
	end

	// Protect pin passes two link-clock flops before use
	always_ff @(posedge sck_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			wp_meta_q <= 1'b1;
			wp_sync_q <= 1'b1;
		end
		else
		begin
			wp_meta_q <= wp_n_i;
			wp_sync_q <= wp_meta_q;
		end
	end

	// Write latch and sleep; power-up clears both
	always_ff @(posedge sck_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			latch_q    <= 1'b0;
			sleeping_q <= 1'b0;
		end
		else if (!cs_n_i && op_evt)
		begin
			if (rx_byte == OP_SET_WRITE_LATCH)
				latch_q <= 1'b1;
			else if (rx_byte == OP_CLEAR_WRITE_LATCH)
				latch_q <= 1'b0;
			else if (rx_byte == OP_SLEEP)
				sleeping_q <= 1'b1;
			else if (rx_byte == OP_WAKE)
				sleeping_q <= 1'b0;
		end
	end

	// Retained status fields; no storage model, so reset stands for delivery
	always_ff @(posedge sck_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			lock_q  <= STATUS_RST[ST_LOCK_BIT];
			bp_q    <= STATUS_RST[ST_BP_HI_BIT:ST_BP_LO_BIT];
			spare_q <= 4'h0;
		end
		else if (!cs_n_i && st_wr_evt)
		begin
			lock_q  <= rx_byte[ST_LOCK_BIT];
			bp_q    <= rx_byte[ST_BP_HI_BIT:ST_BP_LO_BIT];
			spare_q <= {rx_byte[ST_SPARE6_BIT:ST_SPARE4_BIT],
				rx_byte[ST_SPARE0_BIT]};
		end
	end

	// Accepted array bytes wait here while the system clock collects them
	always_ff @(posedge sck_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			wr_hold_q <= '0;
			wr_tgl_q  <= 1'b0;
		end
		else if (!cs_n_i && arr_wr_evt)
		begin
			wr_hold_q <= '{addr: addr_q, data: rx_byte};
			wr_tgl_q  <= ~wr_tgl_q;
		end
	end

	// Status changes announce themselves by a toggle
	always_ff @(posedge sck_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			st_tgl_q <= 1'b0;
		else if (!cs_n_i && (op_evt || st_wr_evt))
			st_tgl_q <= ~st_tgl_q;
	end

	// Output loads at each byte boundary of a read or status read
	assign load_rd = (phase_q == PH_DATA) && (bit_q == 3'h0)
		&& (op_q == OP_READ);
	assign load_st = (phase_q == PH_DATA) && (bit_q == 3'h0)
		&& (op_q == OP_STATUS_READ);

	// Serial output changes on the falling edge, and is reset at once when chip select goes high
	always_ff @(negedge sck_i or posedge frame_rst)
	begin
		if (frame_rst)
		begin
			tx_q   <= 8'h00;
			so_q   <= 1'b0;
			oe_n_q <= 1'b1;
		end
		else if (load_rd)
		begin
			so_q   <= mem_rdata_i[7];
			tx_q   <= {mem_rdata_i[6:0], 1'b0};
			oe_n_q <= 1'b0;
		end
		else if (load_st)
		begin
			// Status repeats for every byte clocked out
			so_q   <= status[7];
			tx_q   <= {status[6:0], 1'b0};
			oe_n_q <= 1'b0;
		end
		else
		begin
			so_q <= tx_q[7];
			tx_q <= {tx_q[6:0], 1'b0};
		end
	end

	assign so_o        = so_q;
	assign so_oe_n_o   = oe_n_q;
	assign mem_raddr_o = addr_q;

	// System side: toggles pass two flops, the third finds the edge
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			wr_sync_q <= 3'h0;
			st_sync_q <= 3'h0;
		end
		else
		begin
			wr_sync_q <= {wr_sync_q[1:0], wr_tgl_q};
			st_sync_q <= {st_sync_q[1:0], st_tgl_q};
		end
	end

	// Hold register is stable for a whole byte time, far above the sync delay
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			mem_wr_o   <= 1'b0;
			mem_wreq_o <= '0;
		end
		else
		begin
			mem_wr_o <= wr_sync_q[2] ^ wr_sync_q[1];
			if (wr_sync_q[2] ^ wr_sync_q[1])
				mem_wreq_o <= wr_hold_q;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			status_o <= '{status: STATUS_RST, sleeping: 1'b0};
		else if (st_sync_q[2] ^ st_sync_q[1])
			status_o <= stat_live;
	end

endmodule

// ---- smp_mram_cmd_checker.sv ----
// Port checks for the serial MRAM command block
`timescale 1ns/100ps
module smp_mram_cmd_checker
(
	input  wire logic         clk_i,
	input  wire logic         sys_rst_i,
	input  wire logic         cs_n_i,
	input  wire logic         so_oe_n_o,
	input  wire logic         mem_wr_o,
	input  smp_pkg::smp_wr_t   mem_wreq_o,
	input  smp_pkg::smp_stat_t status_o
);
	import smp_pkg::*;
	logic [1:0] bp;
	logic [1:0] top;
	assign bp = status_o.status[ST_BP_HI_BIT:ST_BP_LO_BIT];
	assign top = mem_wreq_o.addr[ADDR_W-1:ADDR_W-2];
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);
	sequence s_wr_pulse;
		mem_wr_o ##1 !mem_wr_o;
	endsequence
	a_wr_single: assert property ($rose(mem_wr_o) |-> s_wr_pulse)
		else $error("write pulse too long");
	a_wr_latch: assert property (mem_wr_o |-> status_o.status[1])
		else $error("write with latch clear");
	a_bp_all: assert property (mem_wr_o |-> bp != BP_ALL)
		else $error("write with whole array protected");
	a_bp_half: assert property (mem_wr_o && bp == BP_HALF |-> !top[1])
		else $error("write into protected half");
	a_bp_quarter: assert property
		(mem_wr_o && bp == BP_QUARTER |-> top != TOP_QUARTER)
		else $error("write into protected quarter");
	a_sleep_quiet: assert property (status_o.sleeping |-> !mem_wr_o)
		else $error("write while asleep");
	a_oe_idle: assert property (cs_n_i |-> so_oe_n_o)
		else $error("output driven while deselected");
	a_wreq_held: assert property ($changed(mem_wreq_o) |-> mem_wr_o)
		else $error("write request moved without pulse");
endmodule

// ---- smp_array_model.sv ----
// Behavioural byte array behind the command block
`timescale 1ns/100ps
module smp_array_model
(
	input  wire logic                       clk_i,
	input  wire logic                       wr_i,
	input  smp_pkg::smp_wr_t                wreq_i,
	input  wire logic [smp_pkg::ADDR_W-1:0] raddr_i,
	output logic [smp_pkg::DATA_W-1:0]      rdata_o,
	output int                              wr_cnt_o
);
	import smp_pkg::*;
	logic [DATA_W-1:0] mem_q [0:(1 << ADDR_W)-1];
	// Unwritten bytes read as a pattern, never as stale data
	initial
	begin
		wr_cnt_o = 0;
		for (int a = 0; a < (1 << ADDR_W); a++)
			mem_q[a] = ~a[7:0];
	end
	assign rdata_o = mem_q[raddr_i];
	always @(posedge clk_i)
		if (wr_i)
		begin
			mem_q[wreq_i.addr] <= wreq_i.data;
			wr_cnt_o <= wr_cnt_o + 1;
		end
endmodule

// ---- smp_mram_cmd_test.sv ----
// Testbench for the serial MRAM command block
`timescale 1ns/100ps
module smp_mram_cmd_test;
	import smp_pkg::*;
	logic              clk_i = 0;
	logic              sys_rst_i = 1;
	logic              sck = 0;
	logic              cs_n = 1;
	logic              si = 0;
	logic              wp_n = 1;
	logic              so;
	logic              so_oe_n;
	logic              mem_wr;
	logic [ADDR_W-1:0] raddr;
	logic [DATA_W-1:0] rdata;
	smp_wr_t           wreq;
	smp_stat_t         st;
	int                wcnt;
	int                err_total = 0;
	int                tests_run = 0;
	int                cyc = 0;
	logic [63:0]       rx;
	logic              cpol = 0;
	logic              oe_lo = 0;
	wire               so_w = so_oe_n ? 1'b1 : so; // Pull-up on the line

	smp_mram_cmd smp_mram_cmd_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.sck_i(sck), .cs_n_i(cs_n), .si_i(si), .wp_n_i(wp_n), .so_o(so),
		.so_oe_n_o(so_oe_n), .mem_raddr_o(raddr), .mem_rdata_i(rdata),
		.mem_wr_o(mem_wr), .mem_wreq_o(wreq), .status_o(st));
	smp_array_model smp_array_model_i (.clk_i(clk_i), .wr_i(mem_wr),
		.wreq_i(wreq), .raddr_i(raddr), .rdata_o(rdata), .wr_cnt_o(wcnt));

	initial forever #25 clk_i = ~clk_i;

	task check(input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: %h not %h", $time, seen, exp);
		end
	endtask

	// Link clock runs only inside frames; idle level picks mode 0 or 3
	task frame(input int nb, input logic [63:0] tx);
		@(posedge clk_i) cs_n <= 0;
		oe_lo = 1'b0;
		#100;
		for (int i = nb * 8 - 1; i >= 0; i--)
		begin
			sck = 1'b0;
			si = tx[i];
			#62.5 sck = 1'b1;
			rx = {rx[62:0], so_w};
			oe_lo = oe_lo | !so_oe_n;
			#62.5;
		end
		sck = cpol;
		#40 @(posedge clk_i) cs_n <= 1;
		repeat (12) @(posedge clk_i);
	endtask

	task rds;
		frame(2, {OP_STATUS_READ, 8'h00});
	endtask

	task wr_status(input logic [7:0] v);
		frame(1, OP_SET_WRITE_LATCH);
		frame(2, {OP_STATUS_WRITE, v});
	endtask

	task t_reset;
		check(st, 9'h000);
		check(so_oe_n, 1'b1);
		rds;
		check(rx[7:0], 8'h00);
		$display("reset test done");
	endtask

	task t_latch;
		int n;
		n = wcnt;
		frame(5, {OP_WRITE, 24'h00_0010, 8'h55});
		check(wcnt, n);
		frame(1, OP_SET_WRITE_LATCH);
		check(st.status, 8'h02);
		rds;
		check(rx[7:0], 8'h02);
		frame(1, OP_CLEAR_WRITE_LATCH);
		check(st.status, 8'h00);
		frame(2, {OP_STATUS_WRITE, 8'h0C});
		check(st.status, 8'h00);
		$display("latch test done");
	endtask

	task t_status;
		wr_status(8'h71);
		rds;
		check(rx[7:0], 8'h73);
		wr_status(8'h8C);
		check(st.status, 8'h8E);
		@(posedge clk_i) wp_n <= 0;
		wr_status(8'h00);
		check(st.status, 8'h8E);
		@(posedge clk_i) wp_n <= 1;
		wr_status(8'h00);
		check(st.status, 8'h02);
		$display("status test done");
	endtask

	task t_protect;
		int n;
		int exp[4];
		exp = '{4, 3, 1, 0};
		for (int b = 0; b < 4; b++)
		begin
			wr_status({4'h0, b[1:0], 2'b00});
			n = wcnt;
			frame(6, {OP_WRITE, 24'h03_FFFF, 16'h1122});
			frame(6, {OP_WRITE, 24'h05_FFFF, 16'h3344});
			check(wcnt - n, exp[b]);
		end
		$display("protect test done");
	endtask

	task t_wrap;
		int n;
		wr_status(8'h04);
		n = wcnt;
		frame(6, {OP_WRITE, 24'hFF_FFFF, 16'hAABB});
		check(wcnt - n, 1);
		check(wreq.addr, 19'h0_0000);
		check(oe_lo, 1'b0);
		wr_status(8'h00);
		frame(6, {OP_READ, 24'hFF_FFFF, 16'h0000});
		check(rx[15:0], 16'h00BB);
		check(oe_lo, 1'b1);
		frame(6, {OP_READ, 24'h03_FFFF, 16'h0000});
		check(rx[15:0], 16'h1122);
		$display("wrap test done");
	endtask

	// Clock idles high between frames here
	task t_mode3;
		cpol = 1'b1;
		sck = 1'b1;
		rds;
		check(rx[7:0], 8'h02);
		frame(5, {OP_WRITE, 24'h00_0100, 8'h5A});
		frame(5, {OP_READ, 24'h00_0100, 8'h00});
		check(rx[7:0], 8'h5A);
		cpol = 1'b0;
		sck = 1'b0;
		$display("mode 3 test done");
	endtask

	task t_sleep;
		int n;
		frame(1, OP_SLEEP);
		check(st.sleeping, 1'b1);
		n = wcnt;
		frame(5, {OP_WRITE, 24'h00_0020, 8'h77});
		check(wcnt, n);
		frame(1, OP_CLEAR_WRITE_LATCH);
		check(st.status, 8'h02);
		frame(1, OP_WAKE);
		check(st.sleeping, 1'b0);
		frame(1, OP_SLEEP);
		@(posedge clk_i) sys_rst_i <= 1;
		repeat (2) @(posedge clk_i);
		sys_rst_i <= 0;
		repeat (3) @(posedge clk_i);
		check(st, 9'h000);
		$display("sleep test done");
	endtask

	task test_done;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			err_total++;
			test_done;
		end
	end

	initial
	begin
		repeat (2) @(posedge clk_i);
		sys_rst_i <= 0;
		repeat (2) @(posedge clk_i);
		t_reset;
		t_latch;
		t_status;
		t_protect;
		t_wrap;
		t_mode3;
		t_sleep;
		test_done;
	end
endmodule

bind smp_mram_cmd smp_mram_cmd_checker smp_mram_cmd_checker_i
(
	.clk_i(clk_i),
	.sys_rst_i(sys_rst_i),
	.cs_n_i(cs_n_i),
	.so_oe_n_o(so_oe_n_o),
	.mem_wr_o(mem_wr_o),
	.mem_wreq_o(mem_wreq_o),
	.status_o(status_o)
);
